// *** hdl/timer3_map.svh ***
// register map, field positions and timing constants of the third timer
`ifndef TIMER3_MAP_SVH
`define TIMER3_MAP_SVH

// register byte addresses (word aligned)
`define T3_ADDR_CONTROL    8'h00
`define T3_ADDR_COUNT_LOW  8'h04
`define T3_ADDR_COUNT_HIGH 8'h08
`define T3_ADDR_CAP_LOW    8'h0c
`define T3_ADDR_CAP_HIGH   8'h10

// control register fields
`define T3_BIT_OVF    7
`define T3_BIT_EXF    6
`define T3_BIT_RCLK   5
`define T3_BIT_SERIAL_TX_CLOCK_SELECT   4
`define T3_BIT_EXEN   3
`define T3_BIT_RUN    2
`define T3_BIT_CNT    1
`define T3_BIT_CPRL   0

// reset values
`define T3_CONTROL_RESET 8'h00
`define T3_BYTE_RESET    8'h00

// tick divider: one count every twelve oscillator periods
`define T3_TICK_DIV      4'hc
`define T3_TICK_LAST     4'hb
`define T3_COUNT_MAX     16'hffff

`endif

// *** hdl/timer3_pkg.sv ***
// types shared by the third timer
package timer3_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] count_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b01,
    MODE_RELOAD  = 2'b10
  } mode_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } bus_state_t;
endpackage

// *** hdl/third_timer_capture_reload.sv ***
// third timer/counter with capture, auto-reload and baud clock modes
//------------------------------------------------------------
// Summary of operation
// R01: 16-bit up-counter, timer or event counter
// R02: select 0 counts osc/12, 1 counts falls
// R03: either serial clock select enters baud mode
// R04: capture bit chooses capture else auto-reload
// R05: capture mode counts freely, overflow sets flag
// R06: trigger fall captures count, sets external flag
// R07: reload mode rollover sets flag, reloads count
// R08: reload mode trigger fall forces reload, flag
// R09: overflow flag software cleared, not in baud
// R10: external flag sticky until software clears
// R11: interrupt request when either flag set
// R12: receive clock select routes overflow to receiver
// R13: transmit clock select routes overflow to transmitter
// R14: trigger ignored unless enabled and not baud
// R15: run bit starts and stops, count held
// R16: baud mode forces auto-reload on overflow
// R17: pins sampled, fall is high then low
// R18: control register resets to zero
//------------------------------------------------------------
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "timer3_map.svh"

module third_timer_capture_reload (
  // clock, reset, enable
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 clk_en_in,
  // ahb-lite slave
  input  wire logic                 hsel_in,
  input  wire logic [7:0]           haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic                 hready_in,
  input  wire timer3_pkg::word_t    hwdata_in,
  output logic      [31:0]          hrdata_out,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  // external pins
  input  wire logic                 count_pin_in,
  input  wire logic                 external_trigger_pin_in,
  // timer 1 overflow pulses and serial clocks
  input  wire logic                 timer1_overflow_in,
  output logic                      serial_rx_clock_out,
  output logic                      serial_tx_clock_out,
  // interrupt request to the interrupt controller
  output logic                      timer_irq_out
);
  import timer3_pkg::*;

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  byte_t      timer3_control_reg;
  count_t     count_reg;
  count_t     capture_reload_reg;
  logic [3:0] tick_div_reg;
  logic [1:0] count_sync_reg;
  logic [1:0] trig_sync_reg;
  logic       count_prev_reg;
  logic       trig_prev_reg;
  bus_state_t bus_state_reg;
  logic [7:0] addr_reg;
  logic       wr_reg;
  logic       ovf_pulse_reg;

  // control fields
  logic overflow_flag, external_trigger_flag;
  logic serial_rx_clock_select, serial_tx_clock_select;
  logic external_trigger_enable, run_control;
  logic counter_select, capture_reload_select;
  assign overflow_flag           = timer3_control_reg[`T3_BIT_OVF];
  assign external_trigger_flag   = timer3_control_reg[`T3_BIT_EXF];
  assign serial_rx_clock_select  = timer3_control_reg[`T3_BIT_RCLK];
  assign serial_tx_clock_select  = timer3_control_reg[`T3_BIT_SERIAL_TX_CLOCK_SELECT];
  assign external_trigger_enable = timer3_control_reg[`T3_BIT_EXEN];
  assign run_control             = timer3_control_reg[`T3_BIT_RUN];
  assign counter_select          = timer3_control_reg[`T3_BIT_CNT];
  assign capture_reload_select   = timer3_control_reg[`T3_BIT_CPRL];

  //------------------------------------------------------------
  // mode decode
  //------------------------------------------------------------
  logic  baud_mode;
  mode_t mode;
  assign baud_mode = serial_rx_clock_select | serial_tx_clock_select;  // R03
  // capture bit ignored while clocking the serial port
  assign mode = (capture_reload_select && !baud_mode) ? MODE_CAPTURE
                                                      : MODE_RELOAD;  // R04 R16

  //------------------------------------------------------------
  // pin synchronisers and edge detection
  //------------------------------------------------------------
  // two flops per pin, then a third stage for edge compare
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_sync_reg <= 2'h3;
      trig_sync_reg  <= 2'h3;
      count_prev_reg <= 1'b1;
      trig_prev_reg  <= 1'b1;
    end else if (clk_en_in) begin
      count_sync_reg <= {count_sync_reg[0], count_pin_in};
      trig_sync_reg  <= {trig_sync_reg[0], external_trigger_pin_in};
      count_prev_reg <= count_sync_reg[1];
      trig_prev_reg  <= trig_sync_reg[1];
    end
  end

  logic count_fall, trig_fall;
  assign count_fall = count_prev_reg & ~count_sync_reg[1];  // R17
  assign trig_fall  = trig_prev_reg & ~trig_sync_reg[1];  // R17

  //------------------------------------------------------------
  // machine-rate tick divider
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_div_reg <= 4'h0;
    end else if (clk_en_in) begin
      if (tick_div_reg == `T3_TICK_LAST) begin
        tick_div_reg <= 4'h0;
      end else begin
        tick_div_reg <= tick_div_reg + 4'h1;
      end
    end
  end

  logic tick, inc, rollover, trig_event;
  // timer ticks at osc/12, counter on pin falls
  assign tick       = counter_select ? count_fall
                                     : (tick_div_reg == `T3_TICK_LAST);  // R02
  assign inc        = run_control & tick;  // R15
  assign rollover   = inc & (count_reg == `T3_COUNT_MAX);
  assign trig_event = external_trigger_enable & ~baud_mode & trig_fall;  // R14

  //------------------------------------------------------------
  // ahb-lite slave
  //------------------------------------------------------------
  logic bus_take, bus_wr;
  assign bus_take = hsel_in & hready_in & htrans_in[1];
  assign bus_wr   = (bus_state_reg == BUS_DATA) & wr_reg;

  // address phase capture
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_state_reg <= BUS_IDLE;
      addr_reg      <= 8'h00;
      wr_reg        <= 1'b0;
    end else if (clk_en_in) begin
      bus_state_reg <= bus_take ? BUS_DATA : BUS_IDLE;
      if (bus_take) begin
        addr_reg <= haddr_in;
        wr_reg   <= hwrite_in;
      end
    end
  end

  assign hreadyout_out = 1'b1;  // zero wait states
  assign hresp_out     = 1'b0;  // always okay

  // read mux, registered at the address phase
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (clk_en_in && bus_take && !hwrite_in) begin
      case (haddr_in)
        `T3_ADDR_CONTROL:    hrdata_out <= {24'h00_0000, timer3_control_reg};
        `T3_ADDR_COUNT_LOW:  hrdata_out <= {24'h00_0000, count_reg[7:0]};
        `T3_ADDR_COUNT_HIGH: hrdata_out <= {24'h00_0000, count_reg[15:8]};
        `T3_ADDR_CAP_LOW:    hrdata_out <= {24'h00_0000, capture_reload_reg[7:0]};
        `T3_ADDR_CAP_HIGH:   hrdata_out <= {24'h00_0000, capture_reload_reg[15:8]};
        default:             hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

  //------------------------------------------------------------
  // control register
  //------------------------------------------------------------
  logic ovf_set, exf_set;
  assign ovf_set = rollover & ~baud_mode;  // R05 R07 R09
  assign exf_set = trig_event;  // R06 R08 R10

  // flags: hardware set wins over a software clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer3_control_reg <= `T3_CONTROL_RESET;  // R18
    end else if (clk_en_in) begin
      if (bus_wr && addr_reg == `T3_ADDR_CONTROL) begin
        timer3_control_reg <= hwdata_in[7:0];  // R15
      end
      if (ovf_set) begin
        timer3_control_reg[`T3_BIT_OVF] <= 1'b1;  // R09
      end
      if (exf_set) begin
        timer3_control_reg[`T3_BIT_EXF] <= 1'b1;  // R10
      end
    end
  end

  //------------------------------------------------------------
  // counter and capture/reload pair
  //------------------------------------------------------------
  logic do_reload, do_capture;
  assign do_reload  = (mode == MODE_RELOAD) & (rollover | trig_event);  // R07 R08 R16
  assign do_capture = (mode == MODE_CAPTURE) & trig_event;  // R06

  // count; reload beats software write beats increment
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= {`T3_BYTE_RESET, `T3_BYTE_RESET};
    end else if (clk_en_in) begin
      if (do_reload) begin
        count_reg <= capture_reload_reg;  // R07
      end else if (bus_wr && addr_reg == `T3_ADDR_COUNT_LOW) begin
        count_reg[7:0] <= hwdata_in[7:0];
      end else if (bus_wr && addr_reg == `T3_ADDR_COUNT_HIGH) begin
        count_reg[15:8] <= hwdata_in[7:0];
      end else if (inc) begin
        count_reg <= count_reg + 16'h0001;  // R01 R05
      end
    end
  end

  // capture wins over a software write in the same cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_reload_reg <= {`T3_BYTE_RESET, `T3_BYTE_RESET};
    end else if (clk_en_in) begin
      if (do_capture) begin
        capture_reload_reg <= count_reg;  // R06
      end else if (bus_wr && addr_reg == `T3_ADDR_CAP_LOW) begin
        capture_reload_reg[7:0] <= hwdata_in[7:0];
      end else if (bus_wr && addr_reg == `T3_ADDR_CAP_HIGH) begin
        capture_reload_reg[15:8] <= hwdata_in[7:0];
      end
    end
  end

  //------------------------------------------------------------
  // serial clocks and interrupt
  //------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovf_pulse_reg <= 1'b0;
    end else if (clk_en_in) begin
      ovf_pulse_reg <= rollover;
    end
  end

  assign serial_rx_clock_out = serial_rx_clock_select ? ovf_pulse_reg
                                                      : timer1_overflow_in;  // R12
  assign serial_tx_clock_out = serial_tx_clock_select ? ovf_pulse_reg
                                                      : timer1_overflow_in;  // R13
  assign timer_irq_out = overflow_flag | external_trigger_flag;  // R11

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence roll_s;
    clk_en_in && rollover && !baud_mode;
  endsequence

  ovf_flag_set_a: assert property (roll_s |=> overflow_flag)  // R09
    else $error("overflow flag not set after rollover");
  baud_no_ovf_a: assert property (clk_en_in && baud_mode && !overflow_flag
      && !(bus_wr && addr_reg == `T3_ADDR_CONTROL) |=> !overflow_flag)  // R09
    else $error("overflow flag set in baud mode");
  exf_set_a: assert property (clk_en_in && trig_event |=> external_trigger_flag)  // R10
    else $error("external flag not set on trigger");
  trig_ignore_a: assert property (clk_en_in && trig_fall && !external_trigger_enable
      && !external_trigger_flag && !(bus_wr && addr_reg == `T3_ADDR_CONTROL)
      |=> !external_trigger_flag)  // R14
    else $error("trigger acted while disabled");
  reload_load_a: assert property (clk_en_in && do_reload
      |=> count_reg == $past(capture_reload_reg))  // R07
    else $error("reload value not loaded");
  capture_copy_a: assert property (clk_en_in && do_capture
      |=> capture_reload_reg == $past(count_reg))  // R06
    else $error("capture value wrong");
  stopped_hold_a: assert property (clk_en_in && !run_control && !do_reload
      && !bus_wr |=> $stable(count_reg))  // R15
    else $error("count moved while stopped");
  irq_flags_a: assert property (clk_en_in && (ovf_set || exf_set) |=> timer_irq_out)  // R11
    else $error("interrupt request mismatch");
  tick_rate_a: assert property (clk_en_in && run_control && !counter_select
      && !rollover && !bus_wr && !do_reload |=> count_reg == $past(count_reg)
      + 16'(($past(tick_div_reg) == `T3_TICK_LAST) ? 1 : 0))  // R02
    else $error("timer tick rate wrong");
  free_roll_a: assert property (clk_en_in && rollover && mode == MODE_CAPTURE
      && !bus_wr |=> count_reg == '0)  // R05
    else $error("capture mode rollover did not wrap to zero");
  tx_route_a: assert property (clk_en_in && serial_tx_clock_select && rollover
      && !(bus_wr && addr_reg == `T3_ADDR_CONTROL) |=> serial_tx_clock_out)  // R13
    else $error("transmit clock missed overflow pulse");

endmodule // third_timer_capture_reload

`default_nettype wire

// *** verification/timer3_pins_model.sv ***
// far side model: count and trigger pins plus timer 1 overflow pulses
`timescale 1ns/100ps
`default_nettype none

module timer3_pins_model (
  // clock
  input  wire logic clk_in,
  // pins toward the timer
  output logic      count_pin_out,
  output logic      trigger_pin_out,
  output logic      t1_ovf_out
);
  logic [2:0] div_reg;

  // pins idle high, as with a port pull-up
  initial begin
    count_pin_out   = 1'b1;
    trigger_pin_out = 1'b1;
    t1_ovf_out      = 1'b0;
    div_reg         = 3'h0;
  end

  // timer 1 overflow pulse every eight clocks
  always @(posedge clk_in) begin
    div_reg    <= div_reg + 3'h1;
    t1_ovf_out <= (div_reg == 3'h7);
  end

  // one falling edge, each level held four clocks so the sampler sees it
  task automatic fall(input bit trig);
    repeat (4) @(posedge clk_in);
    if (trig) trigger_pin_out <= 1'b0; else count_pin_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    if (trig) trigger_pin_out <= 1'b1; else count_pin_out <= 1'b1;
  endtask
endmodule // timer3_pins_model

`default_nettype wire

// *** verification/third_timer_capture_reload_tb.sv ***
// self-checking bench of the third timer
`timescale 1ns/100ps
`default_nettype none
`include "timer3_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end

module third_timer_capture_reload_tb;
  import timer3_pkg::*;
  logic       sys_clk, rst_n, hsel, hwrite, hready, irq, clk_en, hresp;
  logic       cnt_pin, trg_pin, t1_ovf, rx_clk, tx_clk;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  word_t      hwdata, hrdata, v;
  int         n_mismatch, check_count, rx_n, tx_n, t1_n, r0, x0, t0;

  third_timer_capture_reload i_third_timer_capture_reload (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .count_pin_in(cnt_pin), .external_trigger_pin_in(trg_pin),
    .timer1_overflow_in(t1_ovf), .serial_rx_clock_out(rx_clk),
    .serial_tx_clock_out(tx_clk), .timer_irq_out(irq));

  timer3_pins_model i_timer3_pins_model (
    .clk_in(sys_clk), .count_pin_out(cnt_pin), .trigger_pin_out(trg_pin),
    .t1_ovf_out(t1_ovf));

  always #4 sys_clk = ~sys_clk;

  // pulse counters of both serial clocks and timer 1
  always @(posedge sys_clk) begin
    rx_n <= rx_n + int'(rx_clk);
    tx_n <= tx_n + int'(tx_clk);
    t1_n <= t1_n + int'(t1_ovf);
  end

  // single ahb-lite transfer: address phase, then data phase
  task automatic bus(input logic wr, input byte_t a, input byte_t wd, output word_t rd);
    haddr <= a; hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h0, wd};
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    word_t x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input byte_t a, input byte_t e);
    word_t x;
    bus(1'b0, a, 8'h00, x);
    `CHK(x, {24'h0, e})
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // reset values and an unmapped place
  task automatic t_reset;
    rd_chk(`T3_ADDR_CONTROL, 8'h00);
    rd_chk(`T3_ADDR_COUNT_HIGH, 8'h00);
    wr(8'h14, 8'h5a);
    rd_chk(8'h14, 8'h00);
    `CHK(irq, 1'b0)
    `CHK(hresp, 1'b0)
    $display("reset test done");
  endtask

  // one count per twelve clocks, held when stopped
  task automatic t_tick;
    word_t w;
    wr(`T3_ADDR_COUNT_LOW, 8'h00);
    wr(`T3_ADDR_CONTROL, 8'h04);
    repeat (240) @(posedge sys_clk);
    wr(`T3_ADDR_CONTROL, 8'h00);
    bus(1'b0, `T3_ADDR_COUNT_LOW, 8'h00, v);
    `CHK(v >= 32'h13 && v <= 32'h15, 1'b1)
    repeat (50) @(posedge sys_clk);
    rd_chk(`T3_ADDR_COUNT_LOW, v[7:0]);
    // clock enable low freezes a running count
    wr(`T3_ADDR_CONTROL, 8'h04);
    bus(1'b0, `T3_ADDR_COUNT_LOW, 8'h00, v);
    clk_en <= 1'b0;
    repeat (120) @(posedge sys_clk);
    clk_en <= 1'b1;
    bus(1'b0, `T3_ADDR_COUNT_LOW, 8'h00, w);
    `CHK(w - v <= 32'h1, 1'b1)
    wr(`T3_ADDR_CONTROL, 8'h00);
    $display("tick test done");
  endtask

  // rollover reloads, sets overflow flag and interrupt
  task automatic t_reload;
    wr(`T3_ADDR_CAP_LOW, 8'h34);
    wr(`T3_ADDR_CAP_HIGH, 8'h12);
    wr(`T3_ADDR_COUNT_LOW, 8'hfe);
    wr(`T3_ADDR_COUNT_HIGH, 8'hff);
    wr(`T3_ADDR_CONTROL, 8'h04);
    repeat (40) @(posedge sys_clk);
    rd_chk(`T3_ADDR_CONTROL, 8'h84);
    rd_chk(`T3_ADDR_COUNT_HIGH, 8'h12);
    `CHK(irq, 1'b1)
    wr(`T3_ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    $display("reload test done");
  endtask

  // capture mode rollover wraps to zero, sets overflow flag, no reload
  task automatic t_free_roll;
    wr(`T3_ADDR_CAP_LOW, 8'h34);
    wr(`T3_ADDR_CAP_HIGH, 8'h12);
    wr(`T3_ADDR_COUNT_LOW, 8'hfe);
    wr(`T3_ADDR_COUNT_HIGH, 8'hff);
    wr(`T3_ADDR_CONTROL, 8'h05);
    repeat (40) @(posedge sys_clk);
    rd_chk(`T3_ADDR_CONTROL, 8'h85);
    rd_chk(`T3_ADDR_COUNT_HIGH, 8'h00);
    rd_chk(`T3_ADDR_CAP_HIGH, 8'h12);
    `CHK(irq, 1'b1)
    wr(`T3_ADDR_CONTROL, 8'h00);
    $display("free roll test done");
  endtask

  // counted falls, then trigger fall captures the count
  task automatic t_capture;
    wr(`T3_ADDR_COUNT_LOW, 8'h00);
    wr(`T3_ADDR_COUNT_HIGH, 8'h00);
    wr(`T3_ADDR_CONTROL, 8'h0f);
    repeat (5) i_timer3_pins_model.fall(1'b0);
    i_timer3_pins_model.fall(1'b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(`T3_ADDR_CAP_LOW, 8'h05);
    rd_chk(`T3_ADDR_CAP_HIGH, 8'h00);
    rd_chk(`T3_ADDR_CONTROL, 8'h4f);
    `CHK(irq, 1'b1)
    wr(`T3_ADDR_CONTROL, 8'h00);
    $display("capture test done");
  endtask

  // trigger ignored when disabled, forces reload when enabled
  task automatic t_trig_reload;
    wr(`T3_ADDR_CAP_LOW, 8'hab);
    wr(`T3_ADDR_CAP_HIGH, 8'hcd);
    wr(`T3_ADDR_CONTROL, 8'h06);
    i_timer3_pins_model.fall(1'b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(`T3_ADDR_CONTROL, 8'h06);
    rd_chk(`T3_ADDR_COUNT_LOW, 8'h05);
    wr(`T3_ADDR_CONTROL, 8'h0e);
    i_timer3_pins_model.fall(1'b1);
    repeat (4) @(posedge sys_clk);
    rd_chk(`T3_ADDR_COUNT_LOW, 8'hab);
    rd_chk(`T3_ADDR_COUNT_HIGH, 8'hcd);
    rd_chk(`T3_ADDR_CONTROL, 8'h4e);
    wr(`T3_ADDR_CONTROL, 8'h00);
    $display("trigger reload test done");
  endtask

  // baud mode: receive then transmit select, reload every 24 clocks
  task automatic t_baud(input byte_t ctl);
    wr(`T3_ADDR_CAP_LOW, 8'hfe);
    wr(`T3_ADDR_CAP_HIGH, 8'hff);
    wr(`T3_ADDR_COUNT_LOW, 8'hfe);
    wr(`T3_ADDR_COUNT_HIGH, 8'hff);
    wr(`T3_ADDR_CONTROL, ctl);
    r0 = rx_n; x0 = tx_n; t0 = t1_n;
    i_timer3_pins_model.fall(1'b1);
    repeat (232) @(posedge sys_clk);
    v = ctl[5] ? word_t'(rx_n - r0) : word_t'(tx_n - x0);
    `CHK(v >= 32'h9 && v <= 32'hb, 1'b1)
    v = ctl[5] ? word_t'(tx_n - x0) : word_t'(rx_n - r0);
    `CHK(v, word_t'(t1_n - t0))
    rd_chk(`T3_ADDR_CONTROL, ctl);
    rd_chk(`T3_ADDR_CAP_LOW, 8'hfe);
    wr(`T3_ADDR_CONTROL, 8'h00);
    $display("baud test done");
  endtask

  initial begin
    sys_clk = 1'b0; rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0;
    haddr = 8'h00; htrans = 2'b00; hwdata = 32'h0;
    clk_en = 1'b1; hsize = 3'b010;
    n_mismatch = 0; check_count = 0; rx_n = 0; tx_n = 0; t1_n = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_tick();
    t_reload();
    t_free_roll();
    t_capture();
    t_trig_reload();
    t_baud(8'h2d);
    t_baud(8'h1d);
    give_verdict();
  end

  // watchdog far beyond the twelve hundred or so cycles the tests need
  initial begin
    #(8 * 20000);
    n_mismatch++;
    give_verdict();
  end
endmodule // third_timer_capture_reload_tb

`default_nettype wire
